// *** src/ctio_defs.svh ***
// Register offsets, field positions and reset values of the camera trigger block.
`ifndef CTIO_DEFS_SVH
`define CTIO_DEFS_SVH

// ==========================================================================
// Register byte addresses
`define CTIO_ADDR_CTRL 8'h00
`define CTIO_ADDR_OUTSEL 8'h04
`define CTIO_ADDR_STATUS 8'h08
`define CTIO_ADDR_BINCFG 8'h0c
`define CTIO_ADDR_COUNT 8'h10

// ==========================================================================
// Control register fields
`define CTIO_CTRL_EDGE 0
`define CTIO_CTRL_GATED 1
`define CTIO_CTRL_ARM 2
`define CTIO_CTRL_MASKMODE 3
`define CTIO_CTRL_RESET 32'h0000_0000

// Output select register fields: source in [2:0], invert in bit 3, per line.
`define CTIO_OUT0_SRC_LSB 0
`define CTIO_OUT0_INV 3
`define CTIO_OUT1_SRC_LSB 8
`define CTIO_OUT1_INV 11
`define CTIO_OUTSEL_RESET 32'h0000_0000

// Binning configuration fields: port count code in [1:0], symmetry error in bit 8.
`define CTIO_BIN_PORTS_LSB 0
`define CTIO_BIN_SYMERR 8

// AXI response codes.
`define CTIO_RESP_OKAY 2'b00
`define CTIO_RESP_SLVERR 2'b10

`endif

// *** src/ctio_pkg.sv ***
// Types shared by the camera trigger block.
package ctio_pkg;

  // Status source choices for each trigger output.
  typedef enum logic [2:0] {
    CTIO_SRC_ACQUIRING = 3'h0,
    CTIO_SRC_HIGH = 3'h1,
    CTIO_SRC_EXPOSING = 3'h2,
    CTIO_SRC_READOUT = 3'h3,
    CTIO_SRC_MASKSHIFT = 3'h4,
    CTIO_SRC_SHUTTER = 3'h5,
    CTIO_SRC_WAITING = 3'h6,
    CTIO_SRC_LOW = 3'h7
  } ctio_src_t;

  // Registered camera status flags that feed the outputs.
  typedef struct packed {
    logic acquiring;
    logic exposing;
    logic readout;
    logic maskShift;
    logic shutterOpen;
    logic waiting;
  } ctio_status_t;

  // Selection and inversion for one output line.
  typedef struct packed {
    logic invert;
    ctio_src_t source;
  } ctio_outcfg_t;

endpackage : ctio_pkg

// *** src/ctio_out_mux.sv ***
// One trigger output line: source selection and optional inversion.
`timescale 1ns/1ps
`default_nettype none

module ctio_out_mux
  import ctio_pkg::*;
(
  // Configuration and status
  input wire ctio_outcfg_t cfg,
  input wire ctio_status_t status,
  // Line
  output logic lineOut
);

  logic selected;

  // Plain combinational pick, so the line follows its flag within the same cycle.
  always_comb begin
    unique case (cfg.source)
      CTIO_SRC_ACQUIRING: selected = status.acquiring | status.waiting;
      CTIO_SRC_HIGH: selected = 1'b1;
      CTIO_SRC_EXPOSING: selected = status.exposing;
      CTIO_SRC_READOUT: selected = status.readout;
      CTIO_SRC_MASKSHIFT: selected = status.maskShift;
      CTIO_SRC_SHUTTER: selected = status.shutterOpen;
      CTIO_SRC_WAITING: selected = status.waiting;
      CTIO_SRC_LOW: selected = 1'b0;
    endcase
    lineOut = selected ^ cfg.invert;
  end

endmodule // ctio_out_mux

`default_nettype wire

// *** src/ctio_trigger_io.sv ***
// Camera trigger input and output logic with an AXI4-Lite register slave.
//
// How it works
// - a setting picks rising or falling edges of the trigger input as active.
// - gated mode, rising selected: expose from rising edge to the falling edge.
// - gated mode, falling selected: expose from falling edge to next rising edge.
// - edges arriving while busy are dropped, never queued, sequence undisturbed.
// - two trigger outputs, each with its own source choice.
// - acquiring source is high while acquiring or waiting for first trigger.
// - constant source holds the output high.
// - exposing source is high exactly while the sensor exposes.
// - readout source is high for the whole readout.
// - masked shift source is high while masked frame shifts run.
// - shutter source is high while the shutter is open.
// - waiting source is high while waiting for an external trigger.
// - each output has its own inversion giving an active-low signal.
// - gated mode opens the shutter on the leading edge, closes on trailing.
`timescale 1ns/1ps
`default_nettype none

`include "ctio_defs.svh"

module ctio_trigger_io
  import ctio_pkg::*;
#(
  parameter int EXPOSE_CYCLES = 64,
  parameter int SHIFT_CYCLES = 16,
  parameter int SHIFT_COUNT = 4,
  parameter int READOUT_CYCLES = 256,
  parameter int SENSOR_COLS = 2048
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Trigger pins
  input wire logic trigIn,
  output logic trigOut0,
  output logic trigOut1,
  // Sensor-side status
  output logic exposing,
  output logic shutterOpen,
  output logic readingOut,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_EXPOSE,
    ST_SHIFT,
    ST_READOUT
  } ctio_state_t;

  // ==========================================================================
  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] outsel_q;
  logic [1:0] binPorts_q;
  logic [31:0] trigCount_q;
  logic [31:0] dropCount_q;
  logic edgeSel;
  logic gatedMode;
  logic armReq;
  logic maskMode;

  assign edgeSel = ctrl_q[`CTIO_CTRL_EDGE];
  assign gatedMode = ctrl_q[`CTIO_CTRL_GATED];
  assign armReq = ctrl_q[`CTIO_CTRL_ARM];
  assign maskMode = ctrl_q[`CTIO_CTRL_MASKMODE];

  // ==========================================================================
  // Trigger input synchroniser and edge detection
  logic syncA_q;
  logic syncB_q;
  logic syncC_q;
  logic riseEdge;
  logic fallEdge;
  logic leadEdge;
  logic trailEdge;

  // Three flops; edges compare the second with the third, so each edge is seen once.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
      syncC_q <= 1'b0;
    end else begin
      syncA_q <= trigIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  assign riseEdge = syncB_q & ~syncC_q;
  assign fallEdge = ~syncB_q & syncC_q;
  // Leading edge is the selected one; trailing is its opposite.
  assign leadEdge = edgeSel ? fallEdge : riseEdge;
  assign trailEdge = edgeSel ? riseEdge : fallEdge;

  // ==========================================================================
  // Acquisition sequencer
  ctio_state_t state_q;
  logic [31:0] timer_q;
  logic [31:0] shiftsLeft_q;
  logic busy;

  assign busy = (state_q != ST_WAIT) && (state_q != ST_IDLE);

  // A lead edge is only honoured in ST_WAIT; elsewhere it is simply dropped.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_IDLE;
      timer_q <= 32'h0000_0000;
      shiftsLeft_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (armReq) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!armReq) begin
            state_q <= ST_IDLE;
          end else if (leadEdge) begin
            state_q <= ST_EXPOSE;
            timer_q <= 32'(EXPOSE_CYCLES);
          end
        end
        ST_EXPOSE: begin
          if (gatedMode) begin
            if (trailEdge) begin
              state_q <= maskMode ? ST_SHIFT : ST_READOUT;
              timer_q <= maskMode ? 32'(SHIFT_CYCLES) : 32'(READOUT_CYCLES);
              shiftsLeft_q <= 32'(SHIFT_COUNT);
            end
          end else if (timer_q <= 32'h0000_0001) begin
            state_q <= maskMode ? ST_SHIFT : ST_READOUT;
            timer_q <= maskMode ? 32'(SHIFT_CYCLES) : 32'(READOUT_CYCLES);
            shiftsLeft_q <= 32'(SHIFT_COUNT);
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        ST_SHIFT: begin
          if (timer_q <= 32'h0000_0001) begin
            if (shiftsLeft_q <= 32'h0000_0001) begin
              state_q <= ST_READOUT;
              timer_q <= 32'(READOUT_CYCLES);
            end else begin
              shiftsLeft_q <= shiftsLeft_q - 32'h0000_0001;
              timer_q <= 32'(SHIFT_CYCLES);
            end
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        ST_READOUT: begin
          if (timer_q <= 32'h0000_0001) begin
            state_q <= armReq ? ST_WAIT : ST_IDLE;
          end else begin
            timer_q <= timer_q - 32'h0000_0001;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Accepted and dropped trigger counters, visible to software.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trigCount_q <= 32'h0000_0000;
      dropCount_q <= 32'h0000_0000;
    end else begin
      if (state_q == ST_WAIT && armReq && leadEdge) trigCount_q <= trigCount_q + 32'h0000_0001;
      if (busy && leadEdge) dropCount_q <= dropCount_q + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Registered status flags
  ctio_status_t status_q;

  // Flags are registered from the current state_q, a cycle behind it, so outputs stay glitch-free.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q.acquiring <= busy;
      status_q.exposing <= (state_q == ST_EXPOSE);
      status_q.readout <= (state_q == ST_READOUT);
      status_q.maskShift <= (state_q == ST_SHIFT);
      status_q.shutterOpen <= (state_q == ST_EXPOSE);
      status_q.waiting <= (state_q == ST_WAIT);
    end
  end

  assign exposing = status_q.exposing;
  assign shutterOpen = status_q.shutterOpen;
  assign readingOut = status_q.readout;

  // ==========================================================================
  // Trigger outputs
  ctio_outcfg_t cfg0;
  ctio_outcfg_t cfg1;
  assign cfg0.source = ctio_src_t'(outsel_q[`CTIO_OUT0_SRC_LSB +: 3]);
  assign cfg0.invert = outsel_q[`CTIO_OUT0_INV];
  assign cfg1.source = ctio_src_t'(outsel_q[`CTIO_OUT1_SRC_LSB +: 3]);
  assign cfg1.invert = outsel_q[`CTIO_OUT1_INV];

  // Two independent lines built from one mux module.
  ctio_out_mux u_out0 (
    .cfg(cfg0),
    .status(status_q),
    .lineOut(trigOut0)
  );

  ctio_out_mux u_out1 (
    .cfg(cfg1),
    .status(status_q),
    .lineOut(trigOut1)
  );

  // ==========================================================================
  // Binning symmetry check
  logic symErr;
  logic [31:0] binRegion_q;
  // Column start and end are the two halves of the region word; software keeps them symmetric, we only flag a miss.
  always_comb begin
    symErr = 1'b0;
    if (binPorts_q != 2'b00) begin
      symErr = (32'(binRegion_q[15:0]) + 32'(binRegion_q[31:16])) != (32'(SENSOR_COLS) - 32'h0000_0001);
    end
  end

  // ==========================================================================
  // AXI4-Lite write path
  logic [7:0] awAddr_q;
  logic awHeld_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHeld_q;

  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;

  // Address and data are captured independently, in either order.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      awAddr_q <= 8'h00;
      awHeld_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      wHeld_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_q <= s_axi_awaddr;
        awHeld_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        wHeld_q <= 1'b1;
      end
      if (awHeld_q && wHeld_q) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Register writes and the write response.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= `CTIO_CTRL_RESET;
      outsel_q <= `CTIO_OUTSEL_RESET;
      binPorts_q <= 2'b00;
      binRegion_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CTIO_RESP_OKAY;
    end else begin
      if (awHeld_q && wHeld_q) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CTIO_RESP_OKAY;
        unique case (awAddr_q)
          `CTIO_ADDR_CTRL: ctrl_q <= applyStrb(ctrl_q, wData_q, wStrb_q);
          `CTIO_ADDR_OUTSEL: outsel_q <= applyStrb(outsel_q, wData_q, wStrb_q);
          `CTIO_ADDR_BINCFG: begin
            if (wStrb_q[0]) binPorts_q <= wData_q[`CTIO_BIN_PORTS_LSB +: 2];
          end
          `CTIO_ADDR_COUNT: binRegion_q <= applyStrb(binRegion_q, wData_q, wStrb_q);
          default: s_axi_bresp <= `CTIO_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read path
  assign s_axi_arready = ~s_axi_rvalid;

  // One-cycle read answer; unmapped addresses give SLVERR with the accepted trigger count as data.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CTIO_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CTIO_RESP_OKAY;
        unique case (s_axi_araddr)
          `CTIO_ADDR_CTRL: s_axi_rdata <= ctrl_q;
          `CTIO_ADDR_OUTSEL: s_axi_rdata <= outsel_q;
          `CTIO_ADDR_STATUS: s_axi_rdata <= {16'h0000, dropCount_q[7:0], 2'b00, status_q};
          `CTIO_ADDR_BINCFG: s_axi_rdata <= {23'h000000, symErr, 6'h00, binPorts_q};
          `CTIO_ADDR_COUNT: s_axi_rdata <= binRegion_q;
          default: begin
            s_axi_rdata <= trigCount_q;
            s_axi_rresp <= `CTIO_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ctio_trigger_io

`default_nettype wire

// *** tb/ctio_trigger_io_assertions.sv ***
// Port-level checks for the camera trigger block.
`timescale 1ns/1ps
`default_nettype none
`include "ctio_defs.svh"
module ctio_trigger_io_assertions
  import ctio_pkg::*;
(
  // Clock, reset and trigger pins
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic trigIn,
  input wire logic trigOut0,
  input wire logic trigOut1,
  // Status
  input wire logic exposing,
  input wire logic shutterOpen,
  input wire logic readingOut,
  // Bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [11:0] ctrl_q;
  logic [11:0] outSel_q;
  logic [3:0] cfgAge_q;
  logic wrBoth;
  logic settled;
  // ==========================================================================
  // Shadow configuration
  // Checks wait a few cycles after a write, since the register lands a cycle late.
  assign wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign settled = cfgAge_q > 4'h3;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= 12'h000;
      outSel_q <= 12'h000;
      cfgAge_q <= 4'h0;
    end else if (wrBoth) begin
      cfgAge_q <= 4'h0;
      if (s_axi_awaddr == `CTIO_ADDR_CTRL) ctrl_q <= s_axi_wdata[11:0];
      if (s_axi_awaddr == `CTIO_ADDR_OUTSEL) outSel_q <= s_axi_wdata[11:0];
    end else if (cfgAge_q != 4'hf) begin
      cfgAge_q <= cfgAge_q + 4'h1;
    end
  end
  // ==========================================================================
  // Properties
  // Trigger held at its inactive level long enough to pass sync and edge logic.
  sequence trigIdleRun;
    (trigIn == ctrl_q[0])[*5];
  endsequence
  chk_gate_rise_end: assert property ((settled && ctrl_q[1] && !ctrl_q[0]) ##0 trigIdleRun |-> !exposing)
    else $error("exposure outlived rising pulse");
  chk_gate_fall_end: assert property ((settled && ctrl_q[1] && ctrl_q[0]) ##0 trigIdleRun |-> !exposing)
    else $error("exposure outlived falling pulse");
  chk_busy_exclusive: assert property (readingOut |-> !exposing)
    else $error("exposure during readout");
  chk_const_line0: assert property (settled && outSel_q[2:0] == CTIO_SRC_HIGH |-> trigOut0 == !outSel_q[3])
    else $error("constant line wrong");
  chk_line1_expose: assert property (settled && outSel_q[10:8] == CTIO_SRC_EXPOSING && $stable(exposing)
    |-> trigOut1 == (exposing ^ outSel_q[11]))
    else $error("line 1 not following exposure");
  chk_line0_readout: assert property (settled && outSel_q[2:0] == CTIO_SRC_READOUT && $stable(readingOut)
    |-> trigOut0 == (readingOut ^ outSel_q[3]))
    else $error("line 0 not following readout");
  chk_line0_shutter: assert property (settled && outSel_q[2:0] == CTIO_SRC_SHUTTER && $stable(shutterOpen)
    |-> trigOut0 == (shutterOpen ^ outSel_q[3]))
    else $error("line 0 not following shutter");
  chk_gated_shutter: assert property (settled && ctrl_q[1] && exposing && $past(exposing) |-> shutterOpen)
    else $error("shutter shut during gated exposure");
  chk_reset_quiet: assert property ($fell(rst) |-> !exposing && !readingOut && !trigOut0 && !trigOut1)
    else $error("outputs active after reset");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (wrBoth |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule // ctio_trigger_io_assertions
`default_nettype wire

// *** tb/ctio_trig_source.sv ***
// Behavioural model of the experiment equipment that pulses the trigger line.
`timescale 1ns/1ps
`default_nettype none
module ctio_trig_source (
  // Clock and command
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic idleLevel,
  input wire logic fire,
  input wire logic [7:0] pulseLen,
  // Trigger line
  output logic trigLine,
  output logic busy
);
  logic [7:0] left_q;
  // ==========================================================================
  // Pulse timer; a request during a running pulse is ignored, like real equipment.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      left_q <= 8'h00;
    end else if (fire && left_q == 8'h00) begin
      left_q <= pulseLen;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // The line leaves its idle level for the whole pulse, so both edges are clean.
  assign trigLine = (left_q != 8'h00) ? ~idleLevel : idleLevel;
  assign busy = left_q != 8'h00;
endmodule // ctio_trig_source
`default_nettype wire

// *** tb/ctio_trigger_io_tb.sv ***
// Self-checking bench for the camera trigger block.
`timescale 1ns/1ps
`default_nettype none
`include "ctio_defs.svh"
module ctio_trigger_io_tb
  import ctio_pkg::*;
;
  logic clk_sys, rst, fire, idleLevel, trigIn, pBusy, trigOut0, trigOut1, exposing, shutterOpen, readingOut;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [7:0] awAddr, arAddr, pulseLen;
  logic [31:0] wData, rData, word;
  logic [1:0] bResp, rResp, resp;
  int errors, total_checks, seed, drops, width, n, m;
  ctio_trigger_io #(.EXPOSE_CYCLES(8), .SHIFT_CYCLES(4), .SHIFT_COUNT(2), .READOUT_CYCLES(16)) i_ctio_trigger_io (
    .clk_sys(clk_sys), .rst(rst), .trigIn(trigIn), .trigOut0(trigOut0), .trigOut1(trigOut1),
    .exposing(exposing), .shutterOpen(shutterOpen), .readingOut(readingOut),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  ctio_trig_source i_ctio_trig_source (.clk_sys(clk_sys), .rst(rst), .idleLevel(idleLevel), .fire(fire),
    .pulseLen(pulseLen), .trigLine(trigIn), .busy(pBusy));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ==========================================================================
  // Comparison, verdict, bus and trigger pulse tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] expected);
    total_checks++;
    if (seen !== expected) begin
      errors++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic giveUp();
    errors++;
    conclude();
  endtask
  // Each task opens with an edge so two calls never drive a strobe in one step.
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_sys);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid === 1'b1) break;
    end
    r = bResp;
    bReady <= 1'b0;
    if (k == 50) giveUp();
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk_sys);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid === 1'b1) break;
    end
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    if (k == 50) giveUp();
  endtask
  task automatic pulse(input logic [7:0] len);
    @(posedge clk_sys);
    pulseLen <= len;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h0c7a;
    errors = 0;
    total_checks = 0;
    drops = 0;
    {rst, fire, idleLevel, pulseLen} = {1'b1, 1'b0, 1'b0, 8'h00};
    {awAddr, arAddr, wData} = '0;
    {awValid, wValid, bReady, arValid, rReady} = 5'h00;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    axiRead(`CTIO_ADDR_CTRL, word, resp);
    check(word, `CTIO_CTRL_RESET);
    axiRead(`CTIO_ADDR_OUTSEL, word, resp);
    check(word, `CTIO_OUTSEL_RESET);
    axiRead(8'h20, word, resp);
    check({30'h0, resp}, {30'h0, `CTIO_RESP_SLVERR});
    axiWrite(8'h24, 32'h0, resp);
    check({30'h0, resp}, {30'h0, `CTIO_RESP_SLVERR});
    // Symmetric column region under port count codes 1 and 2 raises no error.
    for (m = 1; m < 3; m++) begin
      axiWrite(`CTIO_ADDR_BINCFG, m, resp);
      axiWrite(`CTIO_ADDR_COUNT, 32'h05ff_0200, resp);
      axiRead(`CTIO_ADDR_BINCFG, word, resp);
      check({31'h0, word[8]}, 32'h0);
    end
    // Idle and armed: every source and inversion, the two lines set opposite.
    axiWrite(`CTIO_ADDR_CTRL, 32'h4, resp);
    for (m = 0; m < 16; m++) begin
      axiWrite(`CTIO_ADDR_OUTSEL, {20'h0, m[3:0], 4'h0, m[3:0] ^ 4'h8}, resp);
      repeat (2) @(posedge clk_sys);
      word = {24'h0, 8'b0100_0011 >> m[2:0]} ^ {31'h0, m[3]};
      check({30'h0, trigOut1, trigOut0}, {30'h0, word[0], ~word[0]});
    end
    // Gated exposure, rising then falling edge, with a trigger lost in readout.
    for (m = 0; m < 2; m++) begin
      axiWrite(`CTIO_ADDR_CTRL, 32'h6 | m, resp);
      idleLevel <= m[0];
      axiWrite(`CTIO_ADDR_OUTSEL, 32'h0000_0b05, resp);
      repeat (8) @(posedge clk_sys);
      word = $random(seed);
      pulseLen = 8'd6 + {5'h0, word[2:0]};
      pulse(pulseLen);
      width = 0;
      for (n = 0; n < 200 && readingOut !== 1'b1; n++) begin
        @(posedge clk_sys);
        if (exposing === 1'b1) width++;
        if (width == 2 && exposing === 1'b1) check({30'h0, trigOut1, trigOut0}, 32'h3);
      end
      if (n == 200) giveUp();
      check(width, {24'h0, pulseLen});
      check({31'h0, trigOut1}, 32'h0);
      pulse(8'd2);
      drops++;
      for (n = 0; n < 200 && readingOut !== 1'b0; n++) @(posedge clk_sys);
      if (n == 200) giveUp();
      repeat (8) @(posedge clk_sys);
      check({31'h0, exposing}, 32'h0);
      axiRead(`CTIO_ADDR_STATUS, word, resp);
      check({24'h0, word[15:8]}, drops);
    end
    // Timed exposure with masked shifts: 8 exposing cycles, then 2 shifts of 4 cycles each.
    axiWrite(`CTIO_ADDR_CTRL, 32'hc, resp);
    axiWrite(`CTIO_ADDR_OUTSEL, 32'h0000_0204, resp);
    idleLevel <= 1'b0;
    repeat (8) @(posedge clk_sys);
    pulse(8'd3);
    width = 0;
    m = 0;
    for (n = 0; n < 200 && readingOut !== 1'b1; n++) begin
      @(posedge clk_sys);
      if (trigOut1 === 1'b1) width++;
      if (trigOut0 === 1'b1) m++;
    end
    if (n == 200) giveUp();
    check(width, 32'd8);
    check(m, 32'd8);
    conclude();
  end
endmodule // ctio_trigger_io_tb
bind ctio_trigger_io ctio_trigger_io_assertions i_ctio_trigger_io_assertions (
  .clk_sys(clk_sys), .rst(rst), .trigIn(trigIn), .trigOut0(trigOut0), .trigOut1(trigOut1),
  .exposing(exposing), .shutterOpen(shutterOpen), .readingOut(readingOut),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire
